/* File: src/bst_pkg.sv */
// Purpose: constants shared by the boundary-scan test logic
// Assumes: three-bit instruction, twelve-cell boundary chain
// Notes: cell positions count from the tdo end of the chain
package bst_pkg;
	// ---------------------------------------------------------------
	// instruction register
	// ---------------------------------------------------------------
	localparam int IR_W = 3;
	localparam logic [2:0] IR_EXTEST = 3'h0;
	localparam logic [2:0] IR_SAMPLE = 3'h1;
	localparam logic [2:0] IR_TRISTATE = 3'h5;
	localparam logic [2:0] IR_CONTINUITY = 3'h6;
	localparam logic [2:0] IR_BYPASS = 3'h7;
	localparam logic [2:0] IR_RESET = IR_BYPASS;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	localparam logic BYP_CAPTURE = 1'b0;

	// ---------------------------------------------------------------
	// boundary chain: tdi -> ad0..ad5, ad_oe, ad6, ad7, ce, a0, a1 -> tdo
	// ---------------------------------------------------------------
	localparam int BSR_LEN = 12;
	localparam int POS_A1 = 0;
	localparam int POS_A0 = 1;
	localparam int POS_CE = 2;
	localparam int POS_AD7 = 3;
	localparam int POS_AD6 = 4;
	localparam int POS_ADOE = 5;
	localparam int POS_AD5 = 6;
	localparam int POS_AD4 = 7;
	localparam int POS_AD3 = 8;
	localparam int POS_AD2 = 9;
	localparam int POS_AD1 = 10;
	localparam int POS_AD0 = 11;
	localparam logic [11:0] BSR_RESET = 12'h000;

	// ---------------------------------------------------------------
	// tap controller states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		BST_TLR, BST_RTI,
		BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
		BST_PA_DR, BST_EX2_DR, BST_UPD_DR,
		BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR,
		BST_PA_IR, BST_EX2_IR, BST_UPD_IR
	} bst_state_t;
endpackage

/* File: src/bst_tap.sv */
// Purpose: boundary-scan test port with instruction, bypass and chain
// Assumes: tck from the scan master; core pads on clk
// Notes: rst_b also forces the test logic to its reset state
`timescale 1ns/1ps
module bst_tap
	import bst_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [7:0] core_ad_out,
	input wire logic core_ad_oe,
	input wire logic core_ce_l,
	input wire logic [1:0] core_a,
	input wire logic [7:0] pad_ad_in,
	output logic [7:0] pad_ad_out,
	output logic pad_ad_oe,
	output logic pad_ce_l,
	output logic pad_ce_oe,
	output logic [1:0] pad_a,
	output logic pad_a_oe,
	output logic core_extest,
	output logic core_hiz,
	output logic core_cont
);
	// ---------------------------------------------------------------
	// tap state machine
	// ---------------------------------------------------------------
	bst_state_t state_q;
	bst_state_t state_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			BST_TLR: state_d = tms ? BST_TLR : BST_RTI;
			BST_RTI: state_d = tms ? BST_SEL_DR : BST_RTI;
			BST_SEL_DR: state_d = tms ? BST_SEL_IR : BST_CAP_DR;
			BST_CAP_DR: state_d = tms ? BST_EX1_DR : BST_SH_DR;
			BST_SH_DR: state_d = tms ? BST_EX1_DR : BST_SH_DR;
			BST_EX1_DR: state_d = tms ? BST_UPD_DR : BST_PA_DR;
			BST_PA_DR: state_d = tms ? BST_EX2_DR : BST_PA_DR;
			BST_EX2_DR: state_d = tms ? BST_UPD_DR : BST_SH_DR;
			BST_UPD_DR: state_d = tms ? BST_SEL_DR : BST_RTI;
			BST_SEL_IR: state_d = tms ? BST_TLR : BST_CAP_IR;
			BST_CAP_IR: state_d = tms ? BST_EX1_IR : BST_SH_IR;
			BST_SH_IR: state_d = tms ? BST_EX1_IR : BST_SH_IR;
			BST_EX1_IR: state_d = tms ? BST_UPD_IR : BST_PA_IR;
			BST_PA_IR: state_d = tms ? BST_EX2_IR : BST_PA_IR;
			BST_EX2_IR: state_d = tms ? BST_UPD_IR : BST_SH_IR;
			BST_UPD_IR: state_d = tms ? BST_SEL_DR : BST_RTI;
		endcase
	end

	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= BST_TLR;
		end else begin
			state_q <= state_d;
		end
	end

	// ---------------------------------------------------------------
	// instruction decode
	// ---------------------------------------------------------------
	logic [2:0] test_instr_code_q;
	logic [2:0] ir_sh_q;
	wire mode_extest = (test_instr_code_q == IR_EXTEST);
	wire mode_sample = (test_instr_code_q == IR_SAMPLE);
	wire mode_hiz = (test_instr_code_q == IR_TRISTATE);
	wire mode_cont = (test_instr_code_q == IR_CONTINUITY);
	// anything but extest/sample shifts through bypass
	wire sel_bsr = mode_extest | mode_sample;
	wire in_sh_dr = (state_q == BST_SH_DR);
	wire in_sh_ir = (state_q == BST_SH_IR);

	// ---------------------------------------------------------------
	// pad sampling into tck domain
	// ---------------------------------------------------------------
	logic [11:0] pin_live;
	logic [11:0] pin_s1_q;
	logic [11:0] pin_s2_q;
	assign pin_live[POS_AD0] = pad_ad_in[0];
	assign pin_live[POS_AD1] = pad_ad_in[1];
	assign pin_live[POS_AD2] = pad_ad_in[2];
	assign pin_live[POS_AD3] = pad_ad_in[3];
	assign pin_live[POS_AD4] = pad_ad_in[4];
	assign pin_live[POS_AD5] = pad_ad_in[5];
	assign pin_live[POS_AD6] = pad_ad_in[6];
	assign pin_live[POS_AD7] = pad_ad_in[7];
	assign pin_live[POS_ADOE] = pad_ad_oe;
	assign pin_live[POS_CE] = pad_ce_l;
	assign pin_live[POS_A0] = pad_a[0];
	assign pin_live[POS_A1] = pad_a[1];

	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= BSR_RESET;
			pin_s2_q <= BSR_RESET;
		end else begin
			pin_s1_q <= pin_live;
			pin_s2_q <= pin_s1_q;
		end
	end

	// ---------------------------------------------------------------
	// shift stages
	// ---------------------------------------------------------------
	logic [11:0] bsr_sh_q;
	logic [11:0] bsr_upd_q;
	logic byp_q;

	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			ir_sh_q <= IR_CAPTURE;
		end else if (state_q == BST_CAP_IR) begin
			ir_sh_q <= IR_CAPTURE;
		end else if (in_sh_ir) begin
			ir_sh_q <= {tdi, ir_sh_q[2:1]};
		end
	end

	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			byp_q <= BYP_CAPTURE;
		end else if (state_q == BST_CAP_DR) begin
			byp_q <= BYP_CAPTURE;
		end else if (in_sh_dr && !sel_bsr) begin
			byp_q <= tdi;
		end
	end

	always_ff @(posedge tck or negedge rst_b) begin
		if (!rst_b) begin
			bsr_sh_q <= BSR_RESET;
		end else if (state_q == BST_CAP_DR && sel_bsr) begin
			bsr_sh_q <= pin_s2_q;
		end else if (in_sh_dr && sel_bsr) begin
			bsr_sh_q <= {tdi, bsr_sh_q[11:1]};
		end
	end

	// ---------------------------------------------------------------
	// update stages and tdo on falling tck
	// ---------------------------------------------------------------
	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			test_instr_code_q <= IR_RESET;
		end else if (state_q == BST_TLR) begin
			test_instr_code_q <= IR_RESET;
		end else if (state_q == BST_UPD_IR) begin
			test_instr_code_q <= ir_sh_q;
		end
	end

	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			bsr_upd_q <= BSR_RESET;
		end else if (state_q == BST_UPD_DR && sel_bsr) begin
			bsr_upd_q <= bsr_sh_q;
		end
	end

	wire tdo_bit = in_sh_ir ? ir_sh_q[0] :
		(sel_bsr ? bsr_sh_q[0] : byp_q);

	always_ff @(negedge tck or negedge rst_b) begin
		if (!rst_b) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= tdo_bit;
			tdo_oe <= in_sh_ir | in_sh_dr;
		end
	end

	// ---------------------------------------------------------------
	// pad multiplexers: core owns pads except extest and tristate
	// ---------------------------------------------------------------
	wire [7:0] chain_ad = {bsr_upd_q[POS_AD7], bsr_upd_q[POS_AD6],
		bsr_upd_q[POS_AD5], bsr_upd_q[POS_AD4], bsr_upd_q[POS_AD3],
		bsr_upd_q[POS_AD2], bsr_upd_q[POS_AD1], bsr_upd_q[POS_AD0]};

	assign pad_ad_out = mode_extest ? chain_ad : core_ad_out;
	assign pad_ce_l = mode_extest ? bsr_upd_q[POS_CE] : core_ce_l;
	assign pad_a = mode_extest ? {bsr_upd_q[POS_A1], bsr_upd_q[POS_A0]}
		: core_a;
	// enable cell at 1 drives the data lanes from the chain
	assign pad_ad_oe = mode_hiz ? 1'b0 :
		(mode_extest ? bsr_upd_q[POS_ADOE] : core_ad_oe);
	assign pad_ce_oe = !mode_hiz;
	assign pad_a_oe = !mode_hiz;

	// ---------------------------------------------------------------
	// test mode levels into clk domain for the core
	// ---------------------------------------------------------------
	logic [2:0] mode_s1_q;
	logic [2:0] mode_s2_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_s1_q <= 3'h0;
			mode_s2_q <= 3'h0;
		end else begin
			mode_s1_q <= {mode_cont, mode_hiz, mode_extest};
			mode_s2_q <= mode_s1_q;
		end
	end

	assign core_extest = mode_s2_q[0];
	assign core_hiz = mode_s2_q[1];
	assign core_cont = mode_s2_q[2];
endmodule

/* File: test/bst_tap_checker.sv */
// Purpose: pad and mode checks for bst_tap
// Assumes: mode outputs lag the instruction by 1-2 clk
// Notes: pad checks look 3 clk back past a stable mode
`timescale 1ns/1ps
module bst_tap_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] core_ad_out,
	input wire logic core_ad_oe,
	input wire logic core_ce_l,
	input wire logic [1:0] core_a,
	input wire logic [7:0] pad_ad_out,
	input wire logic pad_ad_oe,
	input wire logic pad_ce_l,
	input wire logic pad_ce_oe,
	input wire logic [1:0] pad_a,
	input wire logic pad_a_oe,
	input wire logic core_extest,
	input wire logic core_hiz,
	input wire logic core_cont
);
	wire ad_eq = pad_ad_out == core_ad_out;
	wire ca_eq = pad_ce_l == core_ce_l && pad_a == core_a;
	wire oe_eq = pad_ad_oe == core_ad_oe;
	wire off_w = !(pad_ad_oe || pad_ce_oe || pad_a_oe);
	wire on_w = pad_ce_oe && pad_a_oe;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	ad_core_a: assert property (!core_extest [*4] |->
		$past(ad_eq, 3))
		else $error("data lanes left core");
	ca_core_a: assert property (!core_extest [*4] |->
		$past(ca_eq, 3))
		else $error("ce or address left core");
	hiz_off_a: assert property (core_hiz [*4] |-> $past(off_w, 3))
		else $error("pad enabled in tristate");
	live_on_a: assert property (!core_hiz [*4] |-> $past(on_w, 3))
		else $error("pad floated outside tristate");
	oe_core_a: assert property (
		(!core_extest && !core_hiz) [*4] |-> $past(oe_eq, 3))
		else $error("lane enable left core");
	cont_keep_a: assert property (core_cont [*4] |->
		$past(oe_eq, 3) && $past(ad_eq, 3))
		else $error("continuity moved pads");
	mode_one_a: assert property (
		$onehot0({core_extest, core_hiz, core_cont}))
		else $error("two modes at once");
	rst_idle_a: assert property ($rose(rst_b) |->
		!(core_extest || core_hiz || core_cont))
		else $error("mode set out of reset");
endmodule
bind bst_tap bst_tap_checker u_chk (.*);

/* File: test/bst_scan_master.sv */
// Purpose: scan master driving the test port
// Assumes: tck idles low between frames
// Notes: tdi is inverted once a frame ends
`timescale 1ns/1ps
module bst_scan_master (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		// released tdo reads as the inverse of its last level
		o = tdo_oe ? tdo : ~tdo;
		#80 tck = 1'b0;
	endtask
	task automatic tlr;
		logic o;
		repeat (5) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
	task automatic scan(input logic ir, input int n, input logic [11:0] d,
		output logic [11:0] q);
		logic o;
		q = '0;
		step(1'b1, 1'b0, o);
		if (ir) step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, d[i], q[i]);
		end
		step(1'b1, ~d[n - 1], o);
		step(1'b0, ~d[n - 1], o);
	endtask
endmodule

/* File: test/tb_boundary_scan_test_logic.sv */
// Purpose: self-checking bench for bst_tap
// Assumes: scan master model drives the test port
// Notes: chain words are listed tdi end first; bit 0 is the tdo end
`timescale 1ns/1ps
module tb_boundary_scan_test_logic import bst_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe, pad_ad_oe, pad_ce_l, pad_ce_oe;
	logic pad_a_oe, core_extest, core_hiz, core_cont;
	logic [7:0] core_ad_out = 8'h3c;
	logic core_ad_oe = 1'b0;
	logic core_ce_l = 1'b1;
	logic [1:0] core_a = 2'h1;
	logic [7:0] pad_ad_in = 8'ha5;
	logic [7:0] pad_ad_out;
	logic [1:0] pad_a;
	logic [11:0] q;
	int error_cnt = 0;
	int check_count = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	bst_tap u_dut (.*);
	bst_scan_master u_jm (.*);
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic finish_test;
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic ir(input logic [2:0] c);
		u_jm.scan(1'b1, 3, {9'h000, c}, q);
		chk(q[2:0] === IR_CAPTURE, "ir capture");
	endtask
	task automatic t_bypass;
		logic [2:0] cs [5] = '{3'h7, 3'h2, 3'h3, 3'h4, 3'h6};
		for (int i = 0; i < 5; i++) begin
			ir(cs[i]);
			u_jm.scan(1'b0, 2, 12'h001, q);
			chk(q[1:0] === {1'b1, BYP_CAPTURE},
				"bypass path");
			chk(pad_ad_out === core_ad_out &&
				pad_ad_oe === core_ad_oe, "pads");
			chk(core_cont === (cs[i] == IR_CONTINUITY), "cont");
		end
	endtask
	task automatic t_sample;
		ir(IR_SAMPLE);
		u_jm.scan(1'b0, 12, 12'h829, q);
		chk(q === 12'ha4e, "sample capture");
		chk(pad_ad_out === core_ad_out && pad_ce_l === core_ce_l, "pads");
	endtask
	task automatic t_extest;
		ir(IR_EXTEST);
		chk(pad_ad_out === 8'h81 && pad_ad_oe === 1'b1, "preload lanes");
		chk(pad_ce_l === 1'b0 && pad_a === 2'h2, "preload ce");
		chk(core_extest === 1'b1, "extest mode");
		u_jm.scan(1'b0, 12, 12'hfc0, q);
		chk(q === 12'ha69, "extest capture");
		chk(pad_ad_out === 8'h3f && pad_ad_oe === 1'b0, "lanes");
	endtask
	task automatic t_tristate;
		ir(IR_TRISTATE);
		@(negedge clk);
		core_ad_oe = 1'b1;
		core_ad_out = 8'hc3;
		repeat (4) @(negedge clk);
		chk(core_hiz === 1'b1 && pad_ad_oe === 1'b0, "lanes float");
		chk(pad_ce_oe === 1'b0 && pad_a_oe === 1'b0, "ce float");
	endtask
	task automatic t_tlr;
		logic o;
		// bypass scan through pause-dr and exit2-dr back into shift
		q = '0;
		u_jm.step(1'b1, 1'b0, o);
		u_jm.step(1'b0, 1'b0, o);
		u_jm.step(1'b0, 1'b0, o);
		u_jm.step(1'b1, 1'b1, q[0]);
		u_jm.step(1'b0, 1'b0, o);
		u_jm.step(1'b1, 1'b0, o);
		u_jm.step(1'b0, 1'b0, o);
		u_jm.step(1'b1, 1'b0, q[1]);
		u_jm.step(1'b1, 1'b0, o);
		u_jm.step(1'b0, 1'b0, o);
		chk(q[1:0] === {1'b1, BYP_CAPTURE}, "pause shift");
		u_jm.tlr;
		@(negedge clk);
		chk(core_hiz === 1'b0 && pad_a_oe === 1'b1, "reset mode");
		chk(pad_ad_out === 8'hc3 && pad_ad_oe === 1'b1, "core lanes");
		chk(tdo_oe === 1'b0, "tdo idle");
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			finish_test;
		end
	end
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		chk(!core_extest && !core_hiz && core_cont === 1'b0, "reset");
		u_jm.tlr;
		t_bypass;
		t_sample;
		t_extest;
		t_tristate;
		t_tlr;
		finish_test;
	end
endmodule
